// ===== hw/asbl_regs.svh
// Timing and field constants for the static memory host controller
`ifndef ASBL_REGS_SVH
`define ASBL_REGS_SVH
`define ASBL_CLK_PERIOD_NS 40
`define ASBL_CO_NS 70
`define ASBL_OE_NS 35
`define ASBL_CW_NS 60
`define ASBL_BW_NS 50
`define ASBL_DS_NS 30
`define ASBL_OD_NS 25
`define ASBL_RC_NS 70
`define ASBL_RECOVERY_MS 5
`define ASBL_SYNC_CYC 4
`define ASBL_LOW_LANE 7:0
`define ASBL_HIGH_LANE 15:8
`define ASBL_CYC_UP(ns) (((ns) + `ASBL_CLK_PERIOD_NS - 1) / `ASBL_CLK_PERIOD_NS)
`define ASBL_CYC_MIN1(ns) ((`ASBL_CYC_UP(ns) < 1) ? 1 : `ASBL_CYC_UP(ns))
`define ASBL_RECOVERY_CYC (`ASBL_RECOVERY_MS * 1000000 / `ASBL_CLK_PERIOD_NS)
`endif

// ===== hw/asbl_pkg.sv
// Types for the static memory host controller
package asbl_pkg;
    typedef enum logic [5:0] {
        ASBL_IDLE = 6'h01,
        ASBL_RD = 6'h02,
        ASBL_WR = 6'h04,
        ASBL_GAP = 6'h08,
        ASBL_RETAIN = 6'h10,
        ASBL_RECOVER = 6'h20
    } asbl_state_e;
    typedef struct packed {
        logic [17:0] word_address;
        logic chip_sel_n;
        logic out_en_n;
        logic rw_sel;
        logic lower_byte_enable_n;
        logic upper_byte_enable_n;
    } asbl_pins_s;
    typedef struct packed {
        logic write;
        logic [1:0] byte_en;
        logic [17:0] addr;
        logic [15:0] wdata;
    } asbl_req_s;
endpackage

// ===== hw/asbl_sync.sv
// Three-stage synchroniser for data lanes from the memory pins
`timescale 1ns/1ns
module asbl_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] out_ff;
    logic [WIDTH-1:0] nxt_out;

    always_comb
    begin
        // Per bit, so a floating lane never stalls the other lane
        nxt_out = (s3_ff & ~(s2_ff ^ s3_ff)) | (out_ff & (s2_ff ^ s3_ff));
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end
        else
        begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign sync_o = out_ff;
endmodule // asbl_sync

// ===== hw/asbl_host.sv
// Host-side controller driving an asynchronous 256K x 16 static memory
`timescale 1ns/1ns
`include "asbl_regs.svh"
module asbl_host #(
    parameter int RECOVERY_CYC = `ASBL_RECOVERY_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire asbl_pkg::asbl_req_s req_i,
    output logic req_ready_o,
    output logic rdata_valid_o,
    output logic [15:0] rdata_o,
    input wire logic retain_req_i,
    output logic retain_o,
    output asbl_pkg::asbl_pins_s pins_o,
    input wire logic [15:0] data_bus_lanes_i,
    output logic [15:0] data_bus_lanes_o,
    output logic data_bus_lanes_oe_o
);
    localparam int RD_CYC = `ASBL_CYC_MIN1(`ASBL_CO_NS);
    localparam int WR_CYC = `ASBL_CYC_MIN1(`ASBL_CW_NS);
    localparam int GAP_CYC = `ASBL_CYC_MIN1(`ASBL_OD_NS);
    // Three flops plus the agreement register before data is usable
    localparam int SYNC_CYC = `ASBL_SYNC_CYC;

    if (RECOVERY_CYC < 1 || RECOVERY_CYC > 32'h00ffffff)
    begin : g_bad_recovery
        $error("RECOVERY_CYC out of range");
    end

    asbl_pkg::asbl_state_e state_ff, nxt_state;
    asbl_pkg::asbl_pins_s pins_ff, nxt_pins;
    logic [23:0] cnt_ff, nxt_cnt;
    logic [15:0] wdata_ff, nxt_wdata;
    logic oe_ff, nxt_oe;
    logic ready_ff, nxt_ready;
    logic rvalid_ff, nxt_rvalid;
    logic [15:0] rdata_ff, nxt_rdata;
    logic retain_ff, nxt_retain;
    logic [15:0] lanes_sync;

    asbl_sync #(
        .WIDTH(16)
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i(data_bus_lanes_i),
        .sync_o(lanes_sync)
    );

    always_comb
    begin
        nxt_state = state_ff;
        nxt_pins = pins_ff;
        nxt_cnt = cnt_ff;
        nxt_wdata = wdata_ff;
        nxt_oe = oe_ff;
        nxt_ready = 1'b0;
        nxt_rvalid = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_retain = retain_ff;
        unique case (state_ff)
            asbl_pkg::ASBL_IDLE:
            begin
                nxt_ready = ~retain_req_i;
                if (retain_req_i)
                begin
                    // Deselect before supply may drop
                    nxt_pins.chip_sel_n = 1'b1;
                    nxt_retain = 1'b1;
                    nxt_state = asbl_pkg::ASBL_RETAIN;
                end
                else if (req_valid_i && ready_ff)
                begin
                    nxt_ready = 1'b0;
                    nxt_pins.word_address = req_i.addr;
                    nxt_pins.lower_byte_enable_n = ~req_i.byte_en[0];
                    nxt_pins.upper_byte_enable_n = ~req_i.byte_en[1];
                    nxt_pins.chip_sel_n = 1'b0;
                    nxt_wdata = req_i.wdata;
                    if (req_i.write)
                    begin
                        // Strobe low with select; output enable held high
                        nxt_pins.rw_sel = 1'b0;
                        nxt_pins.out_en_n = 1'b1;
                        // Lanes driven only once device has floated
                        nxt_oe = 1'b0;
                        nxt_cnt = 24'(WR_CYC);
                        nxt_state = asbl_pkg::ASBL_WR;
                    end
                    else
                    begin
                        nxt_pins.rw_sel = 1'b1;
                        nxt_pins.out_en_n = 1'b0;
                        // Access time plus synchroniser latency
                        nxt_cnt = 24'(RD_CYC + SYNC_CYC);
                        nxt_state = asbl_pkg::ASBL_RD;
                    end
                end
            end
            asbl_pkg::ASBL_RD:
            begin
                nxt_cnt = cnt_ff - 24'h000001;
                if (cnt_ff == 24'h000001)
                begin
                    nxt_rdata = lanes_sync;
                    nxt_rvalid = 1'b1;
                    nxt_pins.chip_sel_n = 1'b1;
                    nxt_pins.out_en_n = 1'b1;
                    nxt_cnt = 24'(GAP_CYC);
                    nxt_state = asbl_pkg::ASBL_GAP;
                end
            end
            asbl_pkg::ASBL_WR:
            begin
                nxt_oe = 1'b1;
                nxt_cnt = cnt_ff - 24'h000001;
                if (cnt_ff == 24'h000001)
                begin
                    // Select and strobe rise together; data held one more cycle
                    nxt_pins.chip_sel_n = 1'b1;
                    nxt_pins.rw_sel = 1'b1;
                    nxt_cnt = 24'(GAP_CYC);
                    nxt_state = asbl_pkg::ASBL_GAP;
                end
            end
            asbl_pkg::ASBL_GAP:
            begin
                nxt_oe = 1'b0;
                nxt_cnt = cnt_ff - 24'h000001;
                if (cnt_ff == 24'h000001)
                begin
                    // Turn-off gap lets a previous read release the bus
                    nxt_state = asbl_pkg::ASBL_IDLE;
                end
            end
            asbl_pkg::ASBL_RETAIN:
            begin
                if (!retain_req_i)
                begin
                    nxt_cnt = 24'(RECOVERY_CYC);
                    nxt_state = asbl_pkg::ASBL_RECOVER;
                end
            end
            asbl_pkg::ASBL_RECOVER:
            begin
                nxt_cnt = cnt_ff - 24'h000001;
                if (cnt_ff == 24'h000001)
                begin
                    nxt_retain = 1'b0;
                    nxt_state = asbl_pkg::ASBL_IDLE;
                end
            end
            default:
            begin
                nxt_state = asbl_pkg::ASBL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_ff <= asbl_pkg::ASBL_IDLE;
            pins_ff <= '{word_address: 18'h00000, chip_sel_n: 1'b1, out_en_n: 1'b1,
                rw_sel: 1'b1, lower_byte_enable_n: 1'b1, upper_byte_enable_n: 1'b1};
            cnt_ff <= 24'h000000;
            wdata_ff <= 16'h0000;
            oe_ff <= 1'b0;
            ready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            retain_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            pins_ff <= nxt_pins;
            cnt_ff <= nxt_cnt;
            wdata_ff <= nxt_wdata;
            oe_ff <= nxt_oe;
            ready_ff <= nxt_ready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            retain_ff <= nxt_retain;
        end
    end

    assign req_ready_o = ready_ff;
    assign rdata_valid_o = rvalid_ff;
    assign rdata_o = rdata_ff;
    assign retain_o = retain_ff;
    assign pins_o = pins_ff;
    assign data_bus_lanes_o = wdata_ff;
    assign data_bus_lanes_oe_o = oe_ff;
endmodule // asbl_host

// ===== verification/asbl_host_properties.sv
// Pin timing checks for the static memory host controller
`timescale 1ns/1ns
module asbl_host_properties (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic req_ready_o,
    input wire logic rdata_valid_o,
    input wire logic retain_o,
    input wire asbl_pkg::asbl_pins_s pins_o,
    input wire logic data_bus_lanes_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire cs_n = pins_o.chip_sel_n;
    wire oe_n = pins_o.out_en_n;
    wire rw = pins_o.rw_sel;
    wire [1:0] be_n = {pins_o.upper_byte_enable_n, pins_o.lower_byte_enable_n};
    chk_cs_access:
        assert property ($fell(cs_n) && rw |-> !rdata_valid_o [*6] ##1 rdata_valid_o)
        else $error("Read data not six cycles after select");
    chk_oe_access:
        assert property (rdata_valid_o |-> !$past(oe_n) && !$past(oe_n, 2))
        else $error("Read data taken too soon after output enable");
    chk_cs_write:
        assert property ($fell(cs_n) && !rw |-> !cs_n [*2] ##1 cs_n)
        else $error("Write select low time wrong");
    chk_lane_hold:
        assert property ($fell(rw) |=> $stable(be_n) && !cs_n)
        else $error("Byte enables not held through write");
    chk_read_rw:
        assert property (!cs_n && rw |=> rw || cs_n)
        else $error("Read/write select dropped in a read");
    chk_no_fight:
        assert property (data_bus_lanes_oe_o |-> !$past(rw))
        else $error("Host drives lanes while device may drive");
    chk_retain_desel:
        assert property (retain_o |-> cs_n && !req_ready_o)
        else $error("Select or ready active during retention");
    chk_cycle_gap:
        assert property ($fell(cs_n) |=> !$fell(cs_n) [*3])
        else $error("Accesses closer than the cycle time");
    cov_read: cover property ($fell(cs_n) && rw);
    cov_write: cover property ($fell(cs_n) && !rw);
    cov_retain: cover property ($rose(retain_o));
endmodule // asbl_host_properties
bind asbl_host asbl_host_properties chk_u (.clock_i(clock_i), .rst_i(rst_i),
    .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o), .retain_o(retain_o),
    .pins_o(pins_o), .data_bus_lanes_oe_o(data_bus_lanes_oe_o));

// ===== verification/asbl_sram_model.sv
// Behavioural 256K x 16 static memory on the host pins
`timescale 1ns/1ns
module asbl_sram_model #(
    parameter int ACC_NS = 70
) (
    input wire asbl_pkg::asbl_pins_s pins_i,
    input wire logic [15:0] lanes_i,
    output logic [15:0] lanes_o
);
    logic [15:0] mem [int];
    logic [15:0] junk = 16'h5a5a;
    int a;
    wire [1:0] on_now = {2{!pins_i.chip_sel_n && !pins_i.out_en_n && pins_i.rw_sel}}
        & ~{pins_i.upper_byte_enable_n, pins_i.lower_byte_enable_n};
    wire [1:0] #(ACC_NS) on_late = on_now;
    // Release is immediate, drive waits the slowest legal access time
    wire [1:0] on = on_now & on_late;
    wire wr = !pins_i.chip_sel_n && !pins_i.rw_sel;
    // Released lanes toggle so a stale value never looks like data
    // Toggles on falling clock edges so sampling never races it
    always #40 junk = ~junk;
    always @*
    begin
        a = int'(pins_i.word_address);
        if (wr && !pins_i.lower_byte_enable_n) mem[a][7:0] = lanes_i[7:0];
        if (wr && !pins_i.upper_byte_enable_n) mem[a][15:8] = lanes_i[15:8];
        lanes_o = junk;
        if (on[0]) lanes_o[7:0] = mem[a][7:0];
        if (on[1]) lanes_o[15:8] = mem[a][15:8];
    end
endmodule // asbl_sram_model

// ===== verification/asbl_host_tb.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ns
module asbl_host_tb;
    localparam int RCY = 8;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic retain_req_i = 1'b0;
    asbl_pkg::asbl_req_s req_i = '0;
    asbl_pkg::asbl_pins_s pins_o;
    logic req_ready_o, rdata_valid_o, retain_o, data_bus_lanes_oe_o;
    logic [15:0] rdata_o, host_q, mem_q;
    wire [15:0] bus = data_bus_lanes_oe_o ? host_q : mem_q;
    int errors = 0;
    int checked = 0;
    always #20 clock_i = ~clock_i;
    asbl_host #(.RECOVERY_CYC(RCY)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o), .retain_req_i(retain_req_i),
        .retain_o(retain_o), .pins_o(pins_o), .data_bus_lanes_i(bus),
        .data_bus_lanes_o(host_q), .data_bus_lanes_oe_o(data_bus_lanes_oe_o));
    asbl_sram_model mem_u (.pins_i(pins_o), .lanes_i(bus), .lanes_o(mem_q));
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait, sampled at the falling edge where outputs are settled
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1)
        begin
            @(negedge clock_i);
            n++;
            if (n > 40)
            begin
                errors++;
                final_report();
            end
        end
    endtask
    task automatic send(input logic w, input logic [1:0] be, input logic [17:0] a,
        input logic [15:0] d);
        @(negedge clock_i);
        req_valid_i = 1'b1;
        req_i = {w, be, a, d};
        wait_hi(req_ready_o);
        @(negedge clock_i);
        req_valid_i = 1'b0;
    endtask
    task automatic rd(input logic [1:0] be, input logic [17:0] a, input logic [15:0] exp);
        send(1'b0, be, a, 16'h0000);
        wait_hi(rdata_valid_o);
        cmp(rdata_o & {{8{be[1]}}, {8{be[0]}}}, exp);
    endtask
    task automatic t_reset();
        cmp({11'h000, pins_o[4:0]}, 16'h001f);
        cmp({15'h0000, data_bus_lanes_oe_o}, 16'h0000);
    endtask
    task automatic t_lanes();
        send(1'b1, 2'h3, 18'h3ffff, 16'h1234);
        send(1'b1, 2'h1, 18'h3ffff, 16'habcd);
        send(1'b1, 2'h2, 18'h3ffff, 16'h5600);
        send(1'b1, 2'h3, 18'h00000, 16'hffff);
        rd(2'h3, 18'h3ffff, 16'h56cd);
        rd(2'h1, 18'h00000, 16'h00ff);
        rd(2'h2, 18'h00000, 16'hff00);
    endtask
    task automatic t_retain();
        int n;
        n = 0;
        @(negedge clock_i);
        retain_req_i = 1'b1;
        wait_hi(retain_o);
        cmp({15'h0000, req_ready_o}, 16'h0000);
        @(negedge clock_i);
        retain_req_i = 1'b0;
        while (retain_o !== 1'b0 && n < 40)
        begin
            @(negedge clock_i);
            n++;
        end
        cmp({15'h0000, n >= RCY && n < 40}, 16'h0001);
        rd(2'h3, 18'h3ffff, 16'h56cd);
    endtask
    initial
    begin
        repeat (5) @(negedge clock_i);
        rst_i = 1'b0;
        t_reset();
        t_lanes();
        t_retain();
        final_report();
    end
endmodule // asbl_host_tb
